/* pin_irq_pkg.sv */
// Package with offsets, field positions, reset values and carrier types for the pin interrupt.
package pin_irq_pkg;

	// Register byte addresses on the AXI4-Lite bus, one aligned word each.
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  CSR_ADDR        = 8'h00;
	localparam logic [7:0]  EVT_STATUS_ADDR = 8'h04;
	localparam logic [7:0]  EVT_CLEAR_ADDR  = 8'h08;
	localparam logic [7:0]  EVT_ENABLE_ADDR = 8'h0c;
	localparam logic [7:0]  VECTOR_ADDR     = 8'h10;
	localparam int          WORD_LSB        = 2;

	// Field positions inside the pin interrupt status and control register.
	localparam int          DETECT_MODE_BIT = 0;
	localparam int          INT_ENABLE_BIT  = 1;
	localparam int          ACK_BIT         = 2;
	localparam int          FLAG_BIT        = 3;
	localparam int          PIN_ENABLE_BIT  = 4;
	localparam int          POLARITY_BIT    = 5;
	localparam int          PULL_DIS_BIT    = 6;
	localparam logic [7:0]  CSR_RESET       = 8'h00;

	// Sticky event bits shared by the status, clear and enable registers.
	localparam int          EVT_W           = 3;
	localparam int          EVT_FLAG_SET    = 0;
	localparam int          EVT_EDGE        = 1;
	localparam int          EVT_ACK_BLOCKED = 2;
	localparam logic [2:0]  EVT_RESET       = 3'h0;

	// Vector served by this request and its handler address pair.
	localparam int          VEC_NUM_W       = 5;
	localparam logic [4:0]  PIN_VECTOR_NUM  = 5'h02;
	localparam logic [4:0]  RESET_VECTOR    = 5'h00;
	localparam logic [15:0] PIN_VECTOR_HI   = 16'hfffa;
	localparam logic [15:0] PIN_VECTOR_LO   = 16'hfffb;
	localparam int          VEC_ADDR_SHIFT  = 8;

	// AXI response codes.
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// Control fields that software writes.
	typedef struct packed {
		logic pull_device_disable;
		logic sense_polarity_select;
		logic pin_function_enable;
		logic pin_interrupt_enable;
		logic detect_mode_select;
	} pin_ctrl_t;

	// Qualified pin observations from the synchroniser.
	typedef struct packed {
		logic edge_hit;
		logic level_hit;
	} pin_detect_t;

	// Request presented toward the CPU vector logic.
	typedef struct packed {
		logic                 request;
		logic [VEC_NUM_W-1:0] number;
		logic [15:0]          handler_hi;
		logic [15:0]          handler_lo;
	} vector_req_t;

endpackage

/* pin_sync_detect.sv */
// Pin synchroniser with polarity-selected edge and level detection.
`timescale 1ns/1ns
module pin_sync_detect
	import pin_irq_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        pin_async,
	input  wire logic        enable,
	input  wire logic        polarity,
	output pin_detect_t      detect
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	// A pin at its asserted level for the chosen polarity.
	function automatic logic asserted(input logic level, input logic pol);
		asserted = pol ? level : ~level;
	endfunction

	// Two flops before any logic; the third keeps the last settled level.
	always_comb begin
		state_next      = state_reg;
		state_next.meta = pin_async;
		state_next.sync = state_reg.meta;
		state_next.prev = state_reg.sync;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Edges compare settled samples only, so each pin edge shows for one cycle.
	always_comb begin
		detect.edge_hit  = enable & asserted(state_reg.sync, polarity)
			& ~asserted(state_reg.prev, polarity); // [R3] [R11]
		detect.level_hit = enable & asserted(state_reg.sync, polarity); // [R3]
	end

endmodule

/* pin_vector_request.sv */
// Registered request toward the CPU vector logic with its vector number and handler address.
`timescale 1ns/1ns
module pin_vector_request
	import pin_irq_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        request_in,
	output vector_req_t      vector
);

	vector_req_t state_reg;
	vector_req_t state_next;

	// The vector fields are constant; only the request follows the flag.
	always_comb begin
		state_next            = state_reg;
		state_next.request    = request_in;
		state_next.number     = PIN_VECTOR_NUM; // [R10]
		state_next.handler_hi = PIN_VECTOR_HI; // [R10]
		state_next.handler_lo = PIN_VECTOR_LO; // [R10]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign vector = state_reg;

endmodule

/* pin_interrupt.sv */
// External pin interrupt request block with its AXI4-Lite register slave.
`timescale 1ns/1ns
//
// What this block does
// R1: The pin acts as interrupt request only while the pin-enable bit is set.
// R2: Pull device is on when pin enabled and pull-disable is 0.
// R3: Polarity bit 0 senses falling edges or low levels, 1 rising or high.
// R4: With rising polarity on an enabled pin the pull becomes a pull-down.
// R5: Mode bit 0 sets the flag on edges only, 1 on edges and levels.
// R6: The read-only flag is set by a qualifying pin event, else reads 0.
// R7: Writing 1 to acknowledge clears the flag; 0 does nothing; it reads 0.
// R8: In level mode the flag stays set while the pin holds its asserted level.
// R9: A CPU request is raised while the flag and the interrupt enable are both 1.
// R10: The request uses vector 2 at handler pair 0xFFFA:FFFB; lower vectors win.
// R11: The pin is synchronised before detection so each edge sets the flag once.
module pin_interrupt
	import pin_irq_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              irq_pin,
	output logic                   pull_up_enable,
	output logic                   pull_down_enable,
	output logic                   event_irq,
	output vector_req_t            cpu_vector
);

	// State of the block outside the synchroniser and vector request, registered as one word.
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              arready;
		logic              aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_got;
		logic [7:0]        w_data;
		logic              w_lane0;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		pin_ctrl_t         ctrl;
		logic              pin_request_flag;
		logic [EVT_W-1:0]  evt_status;
		logic [EVT_W-1:0]  evt_enable;
		logic              pull_up;
		logic              pull_down;
		logic              event_irq;
	} top_state_t;

	top_state_t  state_reg;
	top_state_t  state_next;
	pin_detect_t detect;

	// The protection bits carry nothing this block uses; every access is served alike.
	logic        prot_unused;
	assign prot_unused = ^{awprot, arprot};

	// Word address compare used by both the write and read decoders.
	// A byte address off the word boundary hits nothing, so it is refused, not aliased.
	function automatic logic hit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] offset);
		hit = (addr[ADDR_W-1:WORD_LSB] == offset[ADDR_W-1:WORD_LSB])
			&& (addr[WORD_LSB-1:0] == '0);
	endfunction

	// True when a byte address lands on any register of the map.
	function automatic logic mapped(input logic [ADDR_W-1:0] addr);
		mapped = hit(addr, CSR_ADDR) | hit(addr, EVT_STATUS_ADDR)
			| hit(addr, EVT_CLEAR_ADDR) | hit(addr, EVT_ENABLE_ADDR)
			| hit(addr, VECTOR_ADDR);
	endfunction

	// Status and control byte as software reads it; acknowledge and bit 7 read 0.
	function automatic logic [7:0] csr_image(input top_state_t s);
		logic [7:0] v;
		v                  = CSR_RESET;
		v[DETECT_MODE_BIT] = s.ctrl.detect_mode_select;
		v[INT_ENABLE_BIT]  = s.ctrl.pin_interrupt_enable;
		v[ACK_BIT]         = 1'b0; // [R7]
		v[FLAG_BIT]        = s.pin_request_flag; // [R6]
		v[PIN_ENABLE_BIT]  = s.ctrl.pin_function_enable;
		v[POLARITY_BIT]    = s.ctrl.sense_polarity_select;
		v[PULL_DIS_BIT]    = s.ctrl.pull_device_disable;
		csr_image          = v;
	endfunction

	// Pin detection is reported only while the pin function is on; the synchroniser samples always.
	pin_sync_detect u_detect (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pin_async (irq_pin),
		.enable    (state_reg.ctrl.pin_function_enable), // [R1]
		.polarity  (state_reg.ctrl.sense_polarity_select),
		.detect    (detect)
	);

	// The CPU request follows the flag gated by the enable, one cycle later.
	pin_vector_request u_vector (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.request_in (state_reg.pin_request_flag
			& state_reg.ctrl.pin_interrupt_enable), // [R9]
		.vector     (cpu_vector)
	);

	// Bus handshakes, register writes, flag and event updates in one pass.
	always_comb begin
		logic             wr_fire;
		logic             wr_ok;
		logic             ack_write;
		logic             flag_set;
		logic [EVT_W-1:0] evt_hit;
		logic [EVT_W-1:0] evt_clear;
		logic             pull_on;

		state_next = state_reg;
		wr_fire    = state_reg.aw_got & state_reg.w_got & ~state_reg.bvalid;
		wr_ok      = 1'b0;
		ack_write  = 1'b0;
		evt_clear  = '0;

		// Address and data are taken in either order and held until both are here.
		if (awvalid && state_reg.awready) begin
			state_next.aw_got  = 1'b1;
			state_next.aw_addr = awaddr;
		end
		if (wvalid && state_reg.wready) begin
			state_next.w_got   = 1'b1;
			state_next.w_data  = wdata[7:0];
			state_next.w_lane0 = wstrb[0];
		end

		// A taken response frees the write path.
		if (state_reg.bvalid && bready) begin
			state_next.bvalid = 1'b0;
		end

		// Perform the write once both halves are held; only byte lane 0 is live.
		if (wr_fire) begin
			state_next.aw_got = 1'b0;
			state_next.w_got  = 1'b0;
			state_next.bvalid = 1'b1;
			wr_ok             = mapped(state_reg.aw_addr);
			state_next.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
			if (wr_ok && state_reg.w_lane0) begin
				if (hit(state_reg.aw_addr, CSR_ADDR)) begin
					state_next.ctrl.detect_mode_select    =
						state_reg.w_data[DETECT_MODE_BIT]; // [R5]
					state_next.ctrl.pin_interrupt_enable  =
						state_reg.w_data[INT_ENABLE_BIT]; // [R9]
					state_next.ctrl.pin_function_enable   =
						state_reg.w_data[PIN_ENABLE_BIT]; // [R1]
					state_next.ctrl.sense_polarity_select =
						state_reg.w_data[POLARITY_BIT]; // [R3]
					state_next.ctrl.pull_device_disable   =
						state_reg.w_data[PULL_DIS_BIT]; // [R2]
					ack_write = state_reg.w_data[ACK_BIT]; // [R7]
				end
				if (hit(state_reg.aw_addr, EVT_CLEAR_ADDR)) begin
					evt_clear = state_reg.w_data[EVT_W-1:0];
				end
				if (hit(state_reg.aw_addr, EVT_ENABLE_ADDR)) begin
					state_next.evt_enable = state_reg.w_data[EVT_W-1:0];
				end
			end
		end

		// A read is answered in the cycle after its address is taken.
		if (state_reg.rvalid && rready) begin
			state_next.rvalid = 1'b0;
		end
		if (arvalid && state_reg.arready) begin
			state_next.rvalid = 1'b1;
			state_next.rdata  = '0;
			state_next.rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			if (hit(araddr, CSR_ADDR)) begin
				state_next.rdata[7:0] = csr_image(state_reg);
			end else if (hit(araddr, EVT_STATUS_ADDR)) begin
				state_next.rdata[EVT_W-1:0] = state_reg.evt_status;
			end else if (hit(araddr, EVT_ENABLE_ADDR)) begin
				state_next.rdata[EVT_W-1:0] = state_reg.evt_enable;
			end else if (hit(araddr, VECTOR_ADDR)) begin
				state_next.rdata[VEC_NUM_W-1:0] = PIN_VECTOR_NUM; // [R10]
				state_next.rdata[VEC_ADDR_SHIFT +: 16] = PIN_VECTOR_HI; // [R10]
			end
		end

		// Ready flops are derived from the next state so they never overlap a held item.
		state_next.awready = ~state_next.aw_got & ~state_next.bvalid;
		state_next.wready  = ~state_next.w_got & ~state_next.bvalid;
		state_next.arready = ~state_next.rvalid;

		// Edges always qualify; a held level qualifies only in edge-and-level mode.
		flag_set = detect.edge_hit
			| (state_reg.ctrl.detect_mode_select & detect.level_hit); // [R5] [R6]

		// Acknowledge clears first so a same-cycle event or held level wins.
		if (ack_write) begin
			state_next.pin_request_flag = 1'b0; // [R7]
		end
		if (flag_set) begin
			state_next.pin_request_flag = 1'b1; // [R6] [R8]
		end

		// Sticky events: set wins over a clear written in the same cycle.
		evt_hit                  = '0;
		evt_hit[EVT_FLAG_SET]    = flag_set & ~state_reg.pin_request_flag;
		evt_hit[EVT_EDGE]        = detect.edge_hit;
		evt_hit[EVT_ACK_BLOCKED] = ack_write & flag_set;
		state_next.evt_status    = (state_reg.evt_status & ~evt_clear) | evt_hit;
		state_next.event_irq     = |(state_next.evt_status & state_next.evt_enable);

		// Pull device follows the next control so the pin sees it with the write.
		pull_on = state_next.ctrl.pin_function_enable
			& ~state_next.ctrl.pull_device_disable; // [R2]
		state_next.pull_up   = pull_on & ~state_next.ctrl.sense_polarity_select; // [R4]
		state_next.pull_down = pull_on & state_next.ctrl.sense_polarity_select; // [R4]
	end

	// Reset leaves the pin function off, so no pull is applied until software asks.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg            <= '0;
			state_reg.awready    <= 1'b1;
			state_reg.wready     <= 1'b1;
			state_reg.arready    <= 1'b1;
			state_reg.evt_status <= EVT_RESET;
			state_reg.evt_enable <= EVT_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Every top output but cpu_vector is a field of the registered state.
	assign awready          = state_reg.awready;
	assign wready           = state_reg.wready;
	assign bvalid           = state_reg.bvalid;
	assign bresp            = state_reg.bresp;
	assign arready          = state_reg.arready;
	assign rvalid           = state_reg.rvalid;
	assign rdata            = state_reg.rdata;
	assign rresp            = state_reg.rresp;
	assign pull_up_enable   = state_reg.pull_up;
	assign pull_down_enable = state_reg.pull_down;
	assign event_irq        = state_reg.event_irq;

endmodule

/* irq_source_model.sv */
// External device model that drives or releases the interrupt request pin.
`timescale 1ns/1ns
module irq_source_model (
	input  wire logic aclk,
	input  wire logic drive_en,
	input  wire logic drive_val,
	input  wire logic pull_up_enable,
	input  wire logic pull_down_enable,
	output logic      irq_pin
);
	logic last_reg = 1'b0;

	// A floating pin toggles every cycle, so a design that trusts it is caught.
	always_ff @(posedge aclk) begin
		last_reg <= irq_pin;
	end

	// Released pin follows the active pull device, else floats.
	always_comb begin
		if (drive_en) begin
			irq_pin = drive_val;
		end else if (pull_up_enable) begin
			irq_pin = 1'b1;
		end else if (pull_down_enable) begin
			irq_pin = 1'b0;
		end else begin
			irq_pin = ~last_reg;
		end
	end
endmodule

/* pin_interrupt_checker.sv */
// Concurrent checks on the bus and pin outputs of the pin interrupt block.
`timescale 1ns/1ns
module pin_interrupt_checker
	import pin_irq_pkg::*;
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic              bvalid,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [31:0]       rdata,
	input wire logic [1:0]        rresp,
	input wire logic              rvalid,
	input wire logic              pull_up_enable,
	input wire logic              pull_down_enable,
	input wire vector_req_t       cpu_vector
);
	logic [ADDR_W-1:0] rd_addr_reg;

	// The read answer is judged against the address that was taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_addr_reg <= '0;
		end else if (arvalid && arready) begin
			rd_addr_reg <= araddr;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_ar_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer missing");
	chk_ar_refused: assert property (rvalid |-> !arready)
		else $error("read address taken while answer pending");
	chk_w_refused: assert property (awvalid && awready && wvalid && wready |=> !awready && !wready)
		else $error("write taken twice");
	chk_b_answer: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
		else $error("write response not on time");
	chk_ack_reads_zero: assert property (
		rvalid && rd_addr_reg == CSR_ADDR |-> !rdata[ACK_BIT] && rdata[31:7] == 25'h0)
		else $error("acknowledge bit read back nonzero");
	chk_unmapped_err: assert property (
		rvalid && (rd_addr_reg > VECTOR_ADDR || rd_addr_reg[1:0] != 2'h0)
		|-> rresp == RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_vector_fixed: assert property (cpu_vector.request |->
		cpu_vector.number == PIN_VECTOR_NUM && cpu_vector.handler_hi == PIN_VECTOR_HI
		&& cpu_vector.handler_lo == PIN_VECTOR_LO)
		else $error("vector fields wrong");
	chk_pull_exclusive: assert property (!(pull_up_enable && pull_down_enable))
		else $error("both pull devices on");
endmodule

bind pin_interrupt pin_interrupt_checker chk_inst (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
	.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
	.rvalid(rvalid), .pull_up_enable(pull_up_enable), .pull_down_enable(pull_down_enable),
	.cpu_vector(cpu_vector));

/* test_pin_interrupt.sv */
// Self-checking testbench for the pin interrupt block.
`timescale 1ns/1ns
module test_pin_interrupt
	import pin_irq_pkg::*;
;
	logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, drive_en, drive_val;
	logic              irq_pin, pull_up_enable, pull_down_enable, event_irq;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	vector_req_t       cpu_vector;
	int                mismatches;
	int                n_compared;

	pin_interrupt DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .irq_pin(irq_pin), .pull_up_enable(pull_up_enable),
		.pull_down_enable(pull_down_enable), .event_irq(event_irq), .cpu_vector(cpu_vector));

	irq_source_model partner (.aclk(aclk), .drive_en(drive_en), .drive_val(drive_val),
		.pull_up_enable(pull_up_enable), .pull_down_enable(pull_down_enable),
		.irq_pin(irq_pin));

	// Free-running bus clock.
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("mismatches %0d, compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// A hung handshake is counted and the run is closed at once.
	task automatic stall(input int n);
		if (n >= 40) begin
			mismatches++;
			$display("unexpected at %0t: bus answer never came", $time);
			wrap_up();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (n < 40) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		stall(n);
		chk(32'(bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (n < 40) begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		stall(n);
		chk(rdata, exp);
		chk(32'(rresp), 32'(er));
	endtask

	// Pin changes are given time to pass the synchroniser before anything is read.
	task automatic pin(input logic en, input logic v);
		@(posedge aclk);
		drive_en <= en;
		drive_val <= v;
		repeat (6) @(posedge aclk);
	endtask

	// Order: request, event interrupt, pull-down, pull-up.
	task automatic pins(input logic [3:0] exp);
		repeat (2) @(posedge aclk);
		chk(32'({cpu_vector.request, event_irq, pull_down_enable, pull_up_enable}), 32'(exp));
	endtask

	initial begin
		mismatches = 0;
		n_compared = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'h1;
		drive_en = 1'b1;
		drive_val = 1'b1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CSR_ADDR, 32'h0, RESP_OKAY);
		pins(4'b0000);
		rd(VECTOR_ADDR, {8'h00, PIN_VECTOR_HI, 3'h0, PIN_VECTOR_NUM}, RESP_OKAY);
		rd(8'h40, 32'h0, RESP_SLVERR);
		rd(8'h01, 32'h0, RESP_SLVERR);
		wr(8'h40, 32'h7f, RESP_SLVERR);
		rd(CSR_ADDR, 32'h0, RESP_OKAY);
		wr(CSR_ADDR, 32'h10, RESP_OKAY);
		pins(4'b0001);
		pin(1'b1, 1'b0);
		rd(CSR_ADDR, 32'h18, RESP_OKAY);
		pins(4'b0001);
		rd(EVT_STATUS_ADDR, 32'h3, RESP_OKAY);
		wr(EVT_ENABLE_ADDR, 32'h1, RESP_OKAY);
		rd(EVT_ENABLE_ADDR, 32'h1, RESP_OKAY);
		pins(4'b0101);
		wr(EVT_ENABLE_ADDR, 32'h4, RESP_OKAY);
		pins(4'b0001);
		wr(EVT_CLEAR_ADDR, 32'h7, RESP_OKAY);
		rd(EVT_STATUS_ADDR, 32'h0, RESP_OKAY);
		rd(EVT_CLEAR_ADDR, 32'h0, RESP_OKAY);
		wr(EVT_ENABLE_ADDR, 32'h1, RESP_OKAY);
		pins(4'b0001);
		wr(EVT_ENABLE_ADDR, 32'h0, RESP_OKAY);
		wr(CSR_ADDR, 32'h14, RESP_OKAY);
		rd(CSR_ADDR, 32'h10, RESP_OKAY);
		wr(CSR_ADDR, 32'h12, RESP_OKAY);
		pin(1'b1, 1'b1);
		pin(1'b1, 1'b0);
		rd(CSR_ADDR, 32'h1a, RESP_OKAY);
		pins(4'b1001);
		wr(CSR_ADDR, 32'h12, RESP_OKAY);
		rd(CSR_ADDR, 32'h1a, RESP_OKAY);
		wr(CSR_ADDR, 32'h16, RESP_OKAY);
		rd(CSR_ADDR, 32'h12, RESP_OKAY);
		pins(4'b0001);
		wr(CSR_ADDR, 32'h13, RESP_OKAY);
		rd(CSR_ADDR, 32'h1b, RESP_OKAY);
		wr(CSR_ADDR, 32'h17, RESP_OKAY);
		rd(CSR_ADDR, 32'h1b, RESP_OKAY);
		rd(EVT_STATUS_ADDR, 32'h7, RESP_OKAY);
		pin(1'b0, 1'b0);
		wr(CSR_ADDR, 32'h17, RESP_OKAY);
		rd(CSR_ADDR, 32'h13, RESP_OKAY);
		wr(CSR_ADDR, 32'h30, RESP_OKAY);
		pins(4'b0010);
		pin(1'b1, 1'b0);
		rd(CSR_ADDR, 32'h30, RESP_OKAY);
		pin(1'b1, 1'b1);
		rd(CSR_ADDR, 32'h38, RESP_OKAY);
		wr(CSR_ADDR, 32'h74, RESP_OKAY);
		pins(4'b0000);
		wr(CSR_ADDR, 32'h20, RESP_OKAY);
		pin(1'b1, 1'b0);
		pin(1'b1, 1'b1);
		rd(CSR_ADDR, 32'h20, RESP_OKAY);
		pins(4'b0000);
		// A write without byte lane 0 is answered but changes nothing.
		wstrb <= 4'h0;
		wr(CSR_ADDR, 32'h10, RESP_OKAY);
		wstrb <= 4'h1;
		rd(CSR_ADDR, 32'h20, RESP_OKAY);
		wrap_up();
	end
endmodule
